// >>> core/dpw_pkg.sv
package dpw_pkg;
    // register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_DUTY_LOW = 8'h04;
    localparam logic [7:0] A_DUTY_HIGH = 8'h08;
    localparam logic [7:0] A_CYCLE_LOW = 8'h0c;
    localparam logic [7:0] A_CYCLE_HIGH = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    // control field positions
    localparam int MODE_LSB = 4;
    localparam int DIV_LSB = 2;
    localparam int SRC_LSB = 0;
    // reset values
    localparam logic [6:0] RST_CTRL = 7'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // modes
    localparam logic [2:0] M_OFF = 3'h0;
    localparam logic [2:0] M_TW8 = 3'h2;
    localparam logic [2:0] M_TW16 = 3'h3;
    localparam logic [2:0] M_NRZ = 3'h4;
    localparam logic [2:0] M_DU8 = 3'h5;
    localparam logic [2:0] M_RZ = 3'h6;
    localparam logic [2:0] M_HOLD = 3'h7;
    // clock source selecting the external pin
    localparam logic [1:0] SRC_EXT = 2'h2;
    // divider: half-clock lengths, in half ticks, for settings 0..3
    localparam logic [7:0] DIV_LEN0 = 8'h01;
    localparam logic [7:0] DIV_LEN1 = 8'h04;
    localparam logic [7:0] DIV_LEN2 = 8'h10;
    localparam logic [7:0] DIV_LEN3 = 8'h40;
    localparam logic [15:0] CNT_TOP = 16'hffff;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : dpw_pkg

// >>> core/dpw_tick_if.sv
`timescale 1ns/10ps
interface dpw_tick_if;
    logic tick;
    logic half;
    logic clr;
    modport gen (input clr, output tick, output half);
    modport use_side (input clr, input tick, input half);
endinterface : dpw_tick_if

// >>> core/dpw_div.sv
`timescale 1ns/10ps
module dpw_div import dpw_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic half_tick,
    input wire logic [1:0] div_sel,
    dpw_tick_if.gen tk
);
    typedef struct packed {
        logic [7:0] phase;
        logic tick;
        logic half;
    } dpw_div_st_t;

    dpw_div_st_t s;
    dpw_div_st_t next_s;
    logic [7:0] len;
    logic [7:0] last;

    always_comb begin
        case (div_sel)
            2'h0: len = DIV_LEN0;
            2'h1: len = DIV_LEN1;
            2'h2: len = DIV_LEN2;
            default: len = DIV_LEN3;
        endcase
    end

    // a pwm clock is two half lengths: the first half gives the rz high phase
    assign last = 8'({len[6:0], 1'b0} - 8'h01);
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (tk.clr) begin
            next_s.phase = 8'h00;
        end else if (half_tick) begin
            if (s.phase == last) begin
                next_s.phase = 8'h00;
                next_s.tick = 1'b1;
            end else begin
                next_s.phase = 8'(s.phase + 8'h01);
            end
        end
        next_s.half = (next_s.phase < len);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tk.tick = s.tick;
    assign tk.half = s.half;
endmodule : dpw_div

// >>> core/dpw_sigma.sv
`timescale 1ns/10ps
module dpw_sigma import dpw_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic [15:0] value,
    dpw_tick_if.use_side tk,
    output logic bit_q
);
    typedef struct packed {
        logic [15:0] acc;
        logic q;
    } dpw_sig_st_t;

    dpw_sig_st_t s;
    dpw_sig_st_t next_s;

    // first-order accumulator: carry-out gives exactly value highs per 65536
    // ticks and spreads them evenly instead of bunching
    always_comb begin
        next_s = s;
        if (tk.clr) begin
            next_s = '0;
        end else if (tk.tick) begin
            {next_s.q, next_s.acc} = {1'b0, s.acc} + {1'b0, value};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bit_q = s.q;
endmodule : dpw_sigma

// >>> core/dpw_top.sv
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
// Contract
// - twin 8-bit: low cycle byte is common period, counter wraps after it
// - twin 8-bit: out_a goes low when counter equals low duty byte
// - twin 8-bit: out_b high at high cycle byte, low at high duty byte
// - twin 8-bit: high cycle byte zero starts both outputs together at wrap
// - twin 16-bit: period ignored, counter runs full 16-bit range
// - twin 16-bit: out_a high below duty word, low from equality to wrap
// - twin 16-bit: out_b high below cycle word, low from equality to wrap
// - twin 16-bit: both outputs go high together when counter wraps to zero
// - nrz density: both outputs recomputed every pwm clock
// - nrz density: out_a high exactly duty-word clocks per 65536
// - nrz density: out_b high exactly cycle-word clocks per 65536
// - density modes spread high clocks evenly, grouped only above half density
// - dual 8-bit: each output has its own duty and period
// - dual 8-bit: periods from cycle bytes, duties from duty bytes
// - both outputs share one pwm clock source and one divider
// - rz density: like nrz, but each high clock high for first half only
// - mode 7 stops generation and releases both pins
// - mode 7 holds the pulse counter in reset
module dpw_top import dpw_pkg::*; (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic EXT_CLK_PIN,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic OUT_A,
    output logic OUT_B,
    output logic OUT_A_ACT,
    output logic OUT_B_ACT
);
    typedef struct packed {
        logic [2:0] ext;
        logic ext_lvl;
        logic [6:0] ctrl;
        logic [7:0] dl;
        logic [7:0] dh;
        logic [7:0] cl;
        logic [7:0] ch;
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [7:0] wdata;
        logic wstb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [15:0] cnt;
        logic [7:0] cnt_b;
        logic out_a;
        logic out_b;
        logic act;
    } dpw_st_t;

    dpw_st_t s;
    dpw_st_t next_s;
    dpw_tick_if tk ();
    logic [2:0] mode;
    logic idle_mode;
    logic ext_edge;
    logic half_tick;
    logic sig_a;
    logic sig_b;
    logic [15:0] duty_word;
    logic [15:0] cycle_word;

    assign mode = s.ctrl[MODE_LSB +: 3];
    assign duty_word = {s.dh, s.dl};
    assign cycle_word = {s.ch, s.cl};
    // mode 1 is not supported here and idles like mode 0
    assign idle_mode = (mode == M_OFF) || (mode == M_HOLD) || (mode == 3'h1);
    assign tk.clr = idle_mode;
    // a settled pin change needs the second and third stages to agree
    assign ext_edge = (s.ext[2] == s.ext[1]) && (s.ext[2] != s.ext_lvl);
    // each main clock, or each external pin edge, is one half tick; a pwm clock is two half lengths of the divider setting
    assign half_tick = (s.ctrl[SRC_LSB +: 2] == SRC_EXT) ? ext_edge : 1'b1;

    dpw_div u_div (
        .clk(MCLK),
        .srst(SRST),
        .half_tick(half_tick),
        .div_sel(s.ctrl[DIV_LSB +: 2]),
        .tk(tk)
    );

    dpw_sigma u_sig_a (
        .clk(MCLK),
        .srst(SRST),
        .value(duty_word),
        .tk(tk),
        .bit_q(sig_a)
    );

    dpw_sigma u_sig_b (
        .clk(MCLK),
        .srst(SRST),
        .value(cycle_word),
        .tk(tk),
        .bit_q(sig_b)
    );

    always_comb begin
        next_s = s;
        next_s.ext = {s.ext[1:0], EXT_CLK_PIN};
        if (ext_edge) begin
            next_s.ext_lvl = s.ext[2];
        end
        // write channel: address and data may arrive in either order
        if (AWVALID && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = AWADDR;
        end
        if (WVALID && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata = WDATA[7:0];
            next_s.wstb = WSTRB[0];
        end
        if (BREADY && s.bvalid) begin
            next_s.bvalid = 1'b0;
        end
        if (next_s.aw_held && next_s.w_held && !next_s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OK;
            case (next_s.awaddr)
                A_CTRL: if (next_s.wstb) next_s.ctrl = next_s.wdata[6:0];
                A_DUTY_LOW: if (next_s.wstb) next_s.dl = next_s.wdata;
                A_DUTY_HIGH: if (next_s.wstb) next_s.dh = next_s.wdata;
                A_CYCLE_LOW: if (next_s.wstb) next_s.cl = next_s.wdata;
                A_CYCLE_HIGH: if (next_s.wstb) next_s.ch = next_s.wdata;
                A_STATUS: next_s.bresp = RESP_OK;
                default: next_s.bresp = RESP_ERR;
            endcase
        end
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready = !next_s.w_held && !next_s.bvalid;
        // read channel
        if (RREADY && s.rvalid) begin
            next_s.rvalid = 1'b0;
        end
        if (ARVALID && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = RESP_OK;
            case (ARADDR)
                A_CTRL: next_s.rdata = {25'h0000000, s.ctrl};
                A_DUTY_LOW: next_s.rdata = {24'h000000, s.dl};
                A_DUTY_HIGH: next_s.rdata = {24'h000000, s.dh};
                A_CYCLE_LOW: next_s.rdata = {24'h000000, s.cl};
                A_CYCLE_HIGH: next_s.rdata = {24'h000000, s.ch};
                A_STATUS: next_s.rdata = {13'h0000, s.act, s.out_b, s.out_a, s.cnt};
                default: begin
                    next_s.rdata = 32'h00000000;
                    next_s.rresp = RESP_ERR;
                end
            endcase
        end
        next_s.arready = !next_s.rvalid;
        // pulse generation
        next_s.act = !idle_mode;
        case (mode)
            M_TW8: begin
                if (tk.tick) begin
                    if (s.cnt[7:0] == s.cl) begin
                        next_s.cnt = 16'h0000;
                    end else begin
                        next_s.cnt = {8'h00, 8'(s.cnt[7:0] + 8'h01)};
                    end
                    if (next_s.cnt == 16'h0000) next_s.out_a = 1'b1;
                    if (next_s.cnt[7:0] == s.dl) next_s.out_a = 1'b0;
                    if (next_s.cnt[7:0] == s.ch) next_s.out_b = 1'b1;
                    if (next_s.cnt[7:0] == s.dh) next_s.out_b = 1'b0;
                end
            end
            M_TW16: begin
                if (tk.tick) begin
                    // natural 16-bit rollover: the period bytes play no part
                    next_s.cnt = 16'(s.cnt + 16'h0001);
                end
                // levels rather than set and clear, so a counter left at zero by an
                // idle mode already counts as the high phase when this mode starts
                next_s.out_a = (next_s.cnt < duty_word);
                next_s.out_b = (next_s.cnt < cycle_word);
            end
            M_DU8: begin
                if (tk.tick) begin
                    // two counters on the one shared pwm clock
                    if (s.cnt[7:0] == s.cl) begin
                        next_s.cnt = 16'h0000;
                    end else begin
                        next_s.cnt = {8'h00, 8'(s.cnt[7:0] + 8'h01)};
                    end
                    if (s.cnt_b == s.ch) begin
                        next_s.cnt_b = 8'h00;
                    end else begin
                        next_s.cnt_b = 8'(s.cnt_b + 8'h01);
                    end
                    if (next_s.cnt == 16'h0000) next_s.out_a = 1'b1;
                    if (next_s.cnt[7:0] == s.dl) next_s.out_a = 1'b0;
                    if (next_s.cnt_b == 8'h00) next_s.out_b = 1'b1;
                    if (next_s.cnt_b == s.dh) next_s.out_b = 1'b0;
                end
            end
            M_NRZ: begin
                next_s.out_a = sig_a;
                next_s.out_b = sig_b;
            end
            M_RZ: begin
                // high for the first half only, so edge skew cancels out
                next_s.out_a = sig_a && tk.half;
                next_s.out_b = sig_b && tk.half;
            end
            default: begin
                next_s.cnt = 16'h0000;
                next_s.cnt_b = 8'h00;
                next_s.out_a = 1'b0;
                next_s.out_b = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            s <= '0;
            s.ctrl <= RST_CTRL;
            s.dl <= RST_BYTE;
            s.dh <= RST_BYTE;
            s.cl <= RST_BYTE;
            s.ch <= RST_BYTE;
        end else begin
            s <= next_s;
        end
    end

    assign AWREADY = s.awready;
    assign WREADY = s.wready;
    assign BVALID = s.bvalid;
    assign BRESP = s.bresp;
    assign ARREADY = s.arready;
    assign RVALID = s.rvalid;
    assign RRESP = s.rresp;
    assign RDATA = s.rdata;
    assign OUT_A = s.out_a;
    assign OUT_B = s.out_b;
    assign OUT_A_ACT = s.act;
    assign OUT_B_ACT = s.act;

    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);

    a_tw8_wrap: assert property (
        (mode == M_TW8 && tk.tick && s.cnt[7:0] == s.cl) |=> (s.cnt == 16'h0000))
        else $error("twin 8-bit counter did not wrap at period");
    a_tw8_a_low: assert property (
        (mode == M_TW8 && tk.tick && next_s.cnt[7:0] == s.dl) |=> !OUT_A)
        else $error("out_a not low at duty match");
    a_tw8_b_high: assert property (
        (mode == M_TW8 && tk.tick && next_s.cnt[7:0] == s.ch && s.ch != s.dh) |=> OUT_B)
        else $error("out_b not high at cycle byte match");
    a_tw16_hold: assert property (
        (mode == M_TW16 && $past(mode) == M_TW16 && !tk.tick && $stable(duty_word)
         && $stable(cycle_word)) |=> ($stable(OUT_A) && $stable(OUT_B)))
        else $error("twin 16-bit output moved without a pwm clock");
    a_tw16_sync: assert property (
        (mode == M_TW16 && tk.tick && s.cnt == CNT_TOP && duty_word != 16'h0000
         && cycle_word != 16'h0000) |=> (OUT_A && OUT_B))
        else $error("outputs not high together after rollover");
    a_tw16_step: assert property (
        (mode == M_TW16 && tk.tick) |=> (s.cnt == 16'($past(s.cnt) + 16'h0001)))
        else $error("counter did not step by one");
    a_du8_wrap: assert property (
        (mode == M_DU8 && tk.tick && s.cnt_b == s.ch) |=> (s.cnt_b == 8'h00))
        else $error("out_b counter did not wrap at its period");
    a_tick_space: assert property (
        tk.tick |=> !tk.tick)
        else $error("pwm clocks back to back");
    a_rz_half: assert property (
        (mode == M_RZ && !tk.half) |=> (!OUT_A && !OUT_B))
        else $error("rz output high in second half");
    a_hold_idle: assert property (
        (mode == M_HOLD) |=> (!OUT_A && !OUT_B && !OUT_A_ACT && s.cnt == 16'h0000))
        else $error("mode 7 did not release and clear");
    // compare points: each output must follow its own match on the very next clock
    a_tw8_b_low: assert property (
        (mode == M_TW8 && tk.tick && next_s.cnt[7:0] == s.dh) |=> !OUT_B)
        else $error("out_b not low at high duty byte match");
    a_tw8_both_start: assert property (
        (mode == M_TW8 && tk.tick && s.cnt[7:0] == s.cl && s.ch == 8'h00 && s.dl != 8'h00
         && s.dh != 8'h00) |=> (OUT_A && OUT_B))
        else $error("outputs did not start together at wrap");
    a_tw16_a_low: assert property (
        (mode == M_TW16 && tk.tick && 16'(s.cnt + 16'h0001) == duty_word) |=> !OUT_A)
        else $error("out_a not low at duty word match");
    a_tw16_b_low: assert property (
        (mode == M_TW16 && tk.tick && 16'(s.cnt + 16'h0001) == cycle_word) |=> !OUT_B)
        else $error("out_b not low at cycle word match");
    a_du8_b_low: assert property (
        (mode == M_DU8 && tk.tick && s.cnt_b != s.ch && 8'(s.cnt_b + 8'h01) == s.dh) |=> !OUT_B)
        else $error("out_b not low at its own duty match");
    a_du8_a_wrap: assert property (
        (mode == M_DU8 && tk.tick && s.cnt[7:0] == s.cl) |=> (s.cnt == 16'h0000))
        else $error("out_a counter did not wrap at its period");
    a_nrz_follow: assert property (
        (mode == M_NRZ) |=> (OUT_A == $past(sig_a) && OUT_B == $past(sig_b)))
        else $error("nrz outputs not refreshed every clock");
    a_idle_off: assert property (
        (mode == M_OFF) |=> (!OUT_A && !OUT_B && !OUT_A_ACT && !OUT_B_ACT))
        else $error("mode 0 did not release the pins");
    a_act_drive: assert property (
        (!idle_mode) |=> (OUT_A_ACT && OUT_B_ACT))
        else $error("active mode did not take the pins");
    a_clr_stops: assert property (
        tk.clr |=> (!tk.tick && s.cnt == 16'h0000))
        else $error("idle mode let the counter run");

    c_tw8_wrap: cover property (mode == M_TW8 && tk.tick && s.cnt[7:0] == s.cl);
    c_tw16_roll: cover property (mode == M_TW16 && tk.tick && s.cnt == CNT_TOP);
    c_rz_pulse: cover property (mode == M_RZ && OUT_B ##1 !OUT_B);
    c_write_done: cover property (BVALID && BREADY);
    c_ext_tick: cover property (s.ctrl[SRC_LSB +: 2] == SRC_EXT && tk.tick);
endmodule : dpw_top

// >>> verif/dpw_load.sv
`timescale 1ns/10ps
// passive load on one output pin: pulse width, period, density over a window
module dpw_load import dpw_pkg::*; (
    input wire logic clk,
    input wire logic clr,
    input wire logic pin,
    input wire logic [31:0] win,
    output logic [31:0] high_cnt,
    output logic [31:0] max_run,
    output logic [31:0] last_high,
    output logic [31:0] last_period,
    output logic [31:0] rise_t
);
    logic [31:0] now;
    logic [31:0] elapsed;
    logic [31:0] run;
    logic prev;
    initial begin
        now = 32'h0;
        elapsed = 32'h0;
        run = 32'h0;
        prev = 1'b0;
        high_cnt = 32'h0;
        max_run = 32'h0;
        last_high = 32'h0;
        last_period = 32'h0;
        rise_t = 32'h0;
    end
    always @(posedge clk) begin
        now <= now + 32'h1;
        prev <= pin;
        if (clr) begin
            elapsed <= 32'h0;
            high_cnt <= 32'h0;
            max_run <= 32'h0;
            run <= 32'h0;
        end else begin
            // window freezes so the count never depends on when the bench samples
            if (elapsed < win) begin
                elapsed <= elapsed + 32'h1;
                if (pin) high_cnt <= high_cnt + 32'h1;
            end
            run <= pin ? run + 32'h1 : 32'h0;
            if (pin && (run + 32'h1 > max_run)) max_run <= run + 32'h1;
            if (!pin && prev) last_high <= run;
            if (pin && !prev) begin
                last_period <= now - rise_t;
                rise_t <= now;
            end
        end
    end
endmodule : dpw_load

// >>> verif/dpw_top_tb_top.sv
`timescale 1ns/10ps
module dpw_top_tb_top import dpw_pkg::*; ;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} dpw_rexp_t;
    logic MCLK = 1'b0, SRST = 1'b1, EXT_CLK_PIN = 1'b0;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic [31:0] WDATA = 32'h0;
    logic [3:0] WSTRB = 4'h0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, OUT_A, OUT_B, OUT_A_ACT, OUT_B_ACT;
    logic [1:0] BRESP, RRESP;
    logic [31:0] RDATA;
    logic clr = 1'b0;
    logic [31:0] win = 32'h0;
    logic [31:0] a_cnt, a_max, a_high, a_per, a_rise, b_cnt, b_max, b_high, b_per, b_rise;
    logic [1:0] ext_div = 2'h0;
    logic [7:0] dv;
    int errors = 0, n_compared = 0;
    dpw_rexp_t rq[$];
    dpw_rexp_t e_r;
    logic [1:0] bq[$];
    always #5 MCLK = ~MCLK;
    // free-running external source, one edge every 3 cycles
    always @(posedge MCLK) begin
        ext_div <= (ext_div == 2'h2) ? 2'h0 : ext_div + 2'h1;
        if (ext_div == 2'h2) EXT_CLK_PIN <= ~EXT_CLK_PIN;
    end
    dpw_top u_dpw_top (.MCLK(MCLK), .SRST(SRST), .EXT_CLK_PIN(EXT_CLK_PIN), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .OUT_A(OUT_A), .OUT_B(OUT_B), .OUT_A_ACT(OUT_A_ACT),
        .OUT_B_ACT(OUT_B_ACT));
    dpw_load u_load_a (.clk(MCLK), .clr(clr), .pin(OUT_A), .win(win), .high_cnt(a_cnt),
        .max_run(a_max), .last_high(a_high), .last_period(a_per), .rise_t(a_rise));
    dpw_load u_load_b (.clk(MCLK), .clr(clr), .pin(OUT_B), .win(win), .high_cnt(b_cnt),
        .max_run(b_max), .last_high(b_high), .last_period(b_per), .rise_t(b_rise));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task test_done();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    task wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge MCLK);
        bq.push_back(r);
        AWADDR <= a;
        WDATA <= {24'h0, d};
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge MCLK);
            n++;
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
        end while (!(BVALID && BREADY) && n < 50);
        if (n >= 50) errors++;
        BREADY <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge MCLK);
        rq.push_back('{d: d, m: m, r: r});
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge MCLK);
            n++;
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
        end while (!(RVALID && RREADY) && n < 50);
        if (n >= 50) errors++;
        RREADY <= 1'b0;
    endtask : rd
    // passing through mode 0 first clears the counter, so each case starts from zero
    task cfg(input logic [7:0] c, input logic [7:0] dl, input logic [7:0] dh,
             input logic [7:0] cl, input logic [7:0] ch);
        wr(A_CTRL, 8'h00, 4'h1, RESP_OK);
        wr(A_DUTY_LOW, dl, 4'h1, RESP_OK);
        wr(A_DUTY_HIGH, dh, 4'h1, RESP_OK);
        wr(A_CYCLE_LOW, cl, 4'h1, RESP_OK);
        wr(A_CYCLE_HIGH, ch, 4'h1, RESP_OK);
        wr(A_CTRL, c, 4'h1, RESP_OK);
    endtask : cfg
    task meas(input logic [31:0] w);
        @(posedge MCLK);
        clr <= 1'b1;
        win <= w;
        @(posedge MCLK);
        clr <= 1'b0;
        repeat (w + 4) @(posedge MCLK);
    endtask : meas
    always @(posedge MCLK) begin
        if (BVALID && BREADY && bq.size() != 0) check({30'h0, BRESP}, {30'h0, bq.pop_front()});
        if (RVALID && RREADY && rq.size() != 0) begin
            e_r = rq.pop_front();
            check(RDATA & e_r.m, e_r.d);
            check({30'h0, RRESP}, {30'h0, e_r.r});
        end
    end
    initial begin
        repeat (20000) @(posedge MCLK);
        errors++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge MCLK);
        SRST <= 1'b0;
        repeat (2) @(posedge MCLK);
        void'($urandom(32'hb477));
        for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, 32'hffffffff, RESP_OK);
        rd(8'h18, 32'h0, 32'hffffffff, RESP_ERR);
        wr(8'h18, 8'h5a, 4'hf, RESP_ERR);
        wr(A_DUTY_LOW, 8'h55, 4'h0, RESP_OK);
        rd(A_DUTY_LOW, 32'h0, 32'hffffffff, RESP_OK);
        for (int k = 0; k < 3; k++) begin
            dv = 8'($urandom_range(8, 1));
            cfg(8'h20, dv, 8'h06, 8'h09, 8'h02);
            repeat (80) @(posedge MCLK);
            check(a_per, 32'd20);
            check(a_high, 32'(2 * dv));
            check(b_high, 32'd8);
        end
        rd(A_CTRL, 32'h20, 32'hffffffff, RESP_OK);
        cfg(8'h20, 8'h04, 8'h06, 8'h09, 8'h00);
        repeat (80) @(posedge MCLK);
        check(b_rise, a_rise);
        check(b_high, 32'd12);
        cfg(8'h30, 8'h05, 8'h00, 8'h09, 8'h00);
        repeat (60) @(posedge MCLK);
        check(a_high, 32'd10);
        check(b_high, 32'd18);
        check(b_rise, a_rise);
        // a cycle byte of 9 must not stop the counter short of 16 bits
        repeat (640) @(posedge MCLK);
        rd(A_STATUS, 32'h00040100, 32'h0007ff00, RESP_OK);
        cfg(8'h40, 8'h00, 8'h40, 8'h00, 8'hc0);
        repeat (50) @(posedge MCLK);
        meas(32'd128);
        check(a_cnt, 32'd32);
        check(b_cnt, 32'd96);
        check(a_max, 32'd2);
        // duty word 4001h: low nibble padded as 0001 for a shorter loop
        cfg(8'h40, 8'h01, 8'h40, 8'h10, 8'h40);
        repeat (50) @(posedge MCLK);
        meas(32'd128);
        check(b_max, 32'd2);
        check(a_cnt, 32'd32);
        check(a_max, 32'd2);
        cfg(8'h64, 8'h00, 8'h40, 8'h00, 8'hc0);
        repeat (100) @(posedge MCLK);
        meas(32'd256);
        check(a_cnt, 32'd32);
        check(b_cnt, 32'd96);
        check(b_max, 32'd4);
        cfg(8'h50, 8'h03, 8'h02, 8'h09, 8'h04);
        repeat (80) @(posedge MCLK);
        check(a_per, 32'd20);
        check(a_high, 32'd6);
        check(b_per, 32'd10);
        check(b_high, 32'd4);
        check({30'h0, OUT_A_ACT, OUT_B_ACT}, 32'h3);
        cfg(8'h52, 8'h03, 8'h02, 8'h09, 8'h04);
        repeat (240) @(posedge MCLK);
        check(a_per, 32'd60);
        check(b_per, 32'd30);
        check(b_high, 32'd12);
        wr(A_CTRL, 8'h70, 4'h1, RESP_OK);
        repeat (10) @(posedge MCLK);
        check({28'h0, OUT_A, OUT_B, OUT_A_ACT, OUT_B_ACT}, 32'h0);
        rd(A_STATUS, 32'h0, 32'h0007ffff, RESP_OK);
        repeat (4) @(posedge MCLK);
        test_done();
    end
endmodule : dpw_top_tb_top
